// [hw/ccp_defs.svh]
// register offsets, field positions and reset values of the compare and pwm unit
// Functional notes
// - compare full 16-bit value with timer one
// - match performs action chosen by mode field
// - every compare mode sets flag on match
// - zero control clears latch, releases pin
// - mode 1010 flags only, pin untouched
// - mode 1011 resets timer, starts conversion
// - trigger at match, timer cleared next tick
// - trigger reset never sets overflow flag
// - removed match cancels pending timer reset
// - pwm drives pin; cleared direction bit enables driver
// - period is (limit+1)*4*osc*prescale
// - period match clears timer, sets pin unless new duty is zero, latches
// - postscaler ignored for pwm period
// - duty is low byte plus fraction bits
// - duty writes anytime, applied at period end
// - active duty read-only during pwm
// - active duty plus 2-bit latch buffer
// - time base is timer two plus two bits
// - time base equal duty drives pin low
// - limit 255 gives full 10-bit resolution
// - duty beyond period leaves pin unchanged
`ifndef CCP_DEFS_SVH
`define CCP_DEFS_SVH

`define OFS_CMP_LOW      8'h00
`define OFS_CMP_HIGH     8'h04
`define OFS_CONTROL      8'h08
`define OFS_PERIOD       8'h0c
`define OFS_T1_LOW       8'h10
`define OFS_T1_HIGH      8'h14
`define OFS_T2_COUNT     8'h18
`define OFS_T2_CONTROL   8'h1c
`define OFS_IRQ_FLAGS    8'h20
`define OFS_IRQ_ENABLE   8'h24
`define OFS_AUX          8'h28

`define RST_CONTROL      8'h00
`define RST_PERIOD       8'hff
`define RST_T2_COUNT     8'h00
`define RST_T2_CONTROL   8'h00
`define RST_DIRECTION    1'b1

`define FLAG_T1_OVF      0
`define FLAG_T2_MATCH    1
`define FLAG_UNIT        2
`define FLAG_W           3

`define AUX_T1_ON        0
`define AUX_ADC_ON       1
`define AUX_DIRECTION    2
`define AUX_W            3

`define T2_ON_BIT        2
`define PRESC_MAX_1      4'h0
`define PRESC_MAX_4      4'h3
`define PRESC_MAX_16     4'hf

`endif

// [hw/ccp_pkg.sv]
// types of the compare and pwm unit
package ccp_pkg;
	typedef enum logic [3:0] {
		MODE_OFF     = 4'b0000,
		MODE_TOGGLE  = 4'b0010,
		MODE_SET     = 4'b1000,
		MODE_CLEAR   = 4'b1001,
		MODE_SWINT   = 4'b1010,
		MODE_SPECIAL = 4'b1011
	} unit_mode_t;
	typedef logic [7:0]  byte_t;
	typedef logic [31:0] word_t;
endpackage : ccp_pkg

// [hw/compare_and_pwm_unit.sv]
// compare and pwm unit with its two timers behind an apb slave
`timescale 1ns/1ps
`include "ccp_defs.svh"

module compare_and_pwm_unit (
	// apb slave
	input  wire logic           pclk,
	input  wire logic           presetn,
	input  wire logic           psel,
	input  wire logic           penable,
	input  wire logic           pwrite,
	input  wire logic [7:0]     paddr,
	input  wire ccp_pkg::word_t pwdata,
	output logic                pready,
	output ccp_pkg::word_t      prdata,
	output logic                pslverr,
	// unit output pin
	output logic                unit_pin_out,
	output logic                unit_pin_oe,
	// special event trigger
	output logic                special_event,
	output logic                adc_start
);
	import ccp_pkg::*;

	////////////////////////////////////////////////////////////////////////////////
	// decode helpers

	function automatic logic is_pwm(input logic [3:0] m);
		is_pwm = (m[3:2] == 2'b11);
	endfunction : is_pwm

	function automatic logic is_compare(input logic [3:0] m);
		is_compare = (m == MODE_TOGGLE) || (m == MODE_SET) || (m == MODE_CLEAR) ||
			(m == MODE_SWINT) || (m == MODE_SPECIAL);
	endfunction : is_compare

	// only these modes own the pin; 1010 and 1011 leave it to the port
	function automatic logic owns_pin(input logic [3:0] m);
		owns_pin = (m == MODE_TOGGLE) || (m == MODE_SET) || (m == MODE_CLEAR) || is_pwm(m);
	endfunction : owns_pin

	////////////////////////////////////////////////////////////////////////////////
	// state

	logic [1:0]  phase_r,      phase_nxt;
	logic [15:0] t1_r,         t1_nxt;
	logic [7:0]  t2_r,         t2_nxt;
	logic [3:0]  pre_r,        pre_nxt;
	logic [15:0] cmp_r,        cmp_nxt;
	byte_t       ctrl_r,       ctrl_nxt;
	byte_t       period_r,     period_nxt;
	byte_t       t2ctl_r,      t2ctl_nxt;
	logic [`FLAG_W-1:0] flags_r, flags_nxt;
	logic [`FLAG_W-1:0] ien_r,   ien_nxt;
	logic [`AUX_W-1:0]  aux_r,   aux_nxt;
	logic [1:0]  duty_lsb_r,   duty_lsb_nxt;
	logic        latch_r,      latch_nxt;
	logic        pwm_r,        pwm_nxt;
	logic        match_prev_r, match_prev_nxt;
	logic        sevt_r,       sevt_nxt;
	logic        adc_r,        adc_nxt;
	logic        pin_out_r,    pin_out_nxt;
	logic        pin_oe_r,     pin_oe_nxt;
	logic        pready_r,     pready_nxt;
	word_t       prdata_r,     prdata_nxt;
	logic        pslverr_r,    pslverr_nxt;

	////////////////////////////////////////////////////////////////////////////////
	// combinational terms

	logic [3:0] mode;
	logic       tick;
	logic       match;
	logic       match_rise;
	logic       wr;
	logic       setup;
	logic [3:0] presc_max;
	logic       t2_step;
	logic       period_hit;
	logic [1:0] base_low;
	logic [9:0] time_base;
	logic [9:0] duty_full;
	logic       mapped;

	always_comb begin
		mode       = ctrl_r[3:0];
		tick       = (phase_r == 2'h3);
		match      = is_compare(mode) && (t1_r == cmp_r);
		match_rise = match && !match_prev_r;
		setup      = psel && !penable;
		wr         = psel && penable && pready_r && pwrite;
		mapped     = (paddr[1:0] == 2'h0) && (paddr <= `OFS_AUX);
		// postscaler bits of timer two control are never looked at here
		unique case (t2ctl_r[1:0])
			2'b00:   presc_max = `PRESC_MAX_1;
			2'b01:   presc_max = `PRESC_MAX_4;
			default: presc_max = `PRESC_MAX_16;
		endcase
		t2_step    = tick && t2ctl_r[`T2_ON_BIT] && (pre_r == presc_max);
		period_hit = t2_step && (t2_r == period_r);
		duty_full  = {cmp_r[15:8], duty_lsb_r};
	end

	////////////////////////////////////////////////////////////////////////////////
	// next state

	always_comb begin
		phase_nxt      = phase_r + 2'h1;
		t1_nxt         = t1_r;
		t2_nxt         = t2_r;
		pre_nxt        = pre_r;
		cmp_nxt        = cmp_r;
		ctrl_nxt       = ctrl_r;
		period_nxt     = period_r;
		t2ctl_nxt      = t2ctl_r;
		flags_nxt      = flags_r;
		ien_nxt        = ien_r;
		aux_nxt        = aux_r;
		duty_lsb_nxt   = duty_lsb_r;
		latch_nxt      = latch_r;
		pwm_nxt        = pwm_r;
		match_prev_nxt = match;
		sevt_nxt       = 1'b0;
		adc_nxt        = 1'b0;
		pready_nxt     = setup;
		pslverr_nxt    = setup && !mapped;
		prdata_nxt     = prdata_r;

		// timer one, one step per instruction cycle
		if (tick && aux_r[`AUX_T1_ON]) begin
			if (mode == MODE_SPECIAL && match) begin
				// pending reset is dropped if the match went away
				t1_nxt = 16'h0000;
			end else begin
				t1_nxt = t1_r + 16'h0001;
				if (t1_r == 16'hffff) begin
					flags_nxt[`FLAG_T1_OVF] = 1'b1;
				end
			end
		end

		// timer two with prescaler
		if (tick && t2ctl_r[`T2_ON_BIT]) begin
			pre_nxt = (pre_r == presc_max) ? 4'h0 : pre_r + 4'h1;
		end
		if (period_hit) begin
			t2_nxt = 8'h00;
			flags_nxt[`FLAG_T2_MATCH] = 1'b1;
		end else if (t2_step) begin
			t2_nxt = t2_r + 8'h01;
		end

		// compare actions
		if (mode == MODE_OFF) begin
			latch_nxt = 1'b0;
		end else if (match_rise) begin
			flags_nxt[`FLAG_UNIT] = 1'b1;
			unique case (mode)
				MODE_TOGGLE: latch_nxt = !latch_r;
				MODE_SET:    latch_nxt = 1'b1;
				MODE_CLEAR:  latch_nxt = 1'b0;
				MODE_SPECIAL: begin
					sevt_nxt = 1'b1;
					adc_nxt  = aux_r[`AUX_ADC_ON];
				end
				default:     latch_nxt = latch_r;
			endcase
		end

		// time base as it stands after this edge, so the pin falls on the very edge that
		// reaches the duty value; comparing the current value would add one clock of width
		// two low time base bits: clock phase at 1:1, else prescaler bits
		unique case (t2ctl_r[1:0])
			2'b00:   base_low = phase_nxt;
			2'b01:   base_low = pre_nxt[1:0];
			default: base_low = pre_nxt[3:2];
		endcase
		time_base = {t2_nxt, base_low};

		// pwm engine
		if (!is_pwm(mode)) begin
			pwm_nxt = 1'b0;
		end else if (period_hit) begin
			cmp_nxt[15:8] = cmp_r[7:0];
			duty_lsb_nxt  = ctrl_r[5:4];
			pwm_nxt       = ({cmp_r[7:0], ctrl_r[5:4]} != 10'h000);
		end else if (time_base == duty_full) begin
			// a duty beyond the period never matches, so the pin holds
			pwm_nxt = 1'b0;
		end

		// register writes; a hardware set of a flag that was clear wins over a software clear
		if (wr) begin
			unique case (paddr)
				`OFS_CMP_LOW:    cmp_nxt[7:0] = pwdata[7:0];
				`OFS_CMP_HIGH: begin
					if (!is_pwm(mode)) begin
						cmp_nxt[15:8] = pwdata[7:0];
					end
				end
				`OFS_CONTROL:    ctrl_nxt   = pwdata[7:0];
				`OFS_PERIOD:     period_nxt = pwdata[7:0];
				`OFS_T1_LOW:     t1_nxt[7:0]  = pwdata[7:0];
				`OFS_T1_HIGH:    t1_nxt[15:8] = pwdata[7:0];
				`OFS_T2_COUNT:   t2_nxt     = pwdata[7:0];
				`OFS_T2_CONTROL: t2ctl_nxt  = pwdata[7:0];
				`OFS_IRQ_FLAGS:  flags_nxt  = pwdata[`FLAG_W-1:0] | (flags_nxt & ~flags_r);
				`OFS_IRQ_ENABLE: ien_nxt    = pwdata[`FLAG_W-1:0];
				`OFS_AUX:        aux_nxt    = pwdata[`AUX_W-1:0];
				default:         ;
			endcase
		end

		// pin drive follows the unit's ownership and the direction bit
		pin_out_nxt = is_pwm(mode) ? pwm_nxt : latch_nxt;
		pin_oe_nxt  = owns_pin(mode) && !aux_r[`AUX_DIRECTION];

		// read data captured in the setup cycle
		if (setup) begin
			prdata_nxt = 32'h0000_0000;
			unique case (paddr)
				`OFS_CMP_LOW:    prdata_nxt[7:0] = cmp_r[7:0];
				`OFS_CMP_HIGH:   prdata_nxt[7:0] = cmp_r[15:8];
				`OFS_CONTROL:    prdata_nxt[7:0] = ctrl_r;
				`OFS_PERIOD:     prdata_nxt[7:0] = period_r;
				`OFS_T1_LOW:     prdata_nxt[7:0] = t1_r[7:0];
				`OFS_T1_HIGH:    prdata_nxt[7:0] = t1_r[15:8];
				`OFS_T2_COUNT:   prdata_nxt[7:0] = t2_r;
				`OFS_T2_CONTROL: prdata_nxt[7:0] = t2ctl_r;
				`OFS_IRQ_FLAGS:  prdata_nxt[`FLAG_W-1:0] = flags_r;
				`OFS_IRQ_ENABLE: prdata_nxt[`FLAG_W-1:0] = ien_r;
				`OFS_AUX:        prdata_nxt[`AUX_W-1:0]  = aux_r;
				default:         ;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// registers

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			phase_r      <= 2'h0;
			t1_r         <= 16'h0000;
			t2_r         <= `RST_T2_COUNT;
			pre_r        <= 4'h0;
			cmp_r        <= 16'h0000;
			ctrl_r       <= `RST_CONTROL;
			period_r     <= `RST_PERIOD;
			t2ctl_r      <= `RST_T2_CONTROL;
			flags_r      <= '0;
			ien_r        <= '0;
			aux_r        <= {`RST_DIRECTION, 2'b00};
			duty_lsb_r   <= 2'h0;
			latch_r      <= 1'b0;
			pwm_r        <= 1'b0;
			match_prev_r <= 1'b0;
			sevt_r       <= 1'b0;
			adc_r        <= 1'b0;
			pin_out_r    <= 1'b0;
			pin_oe_r     <= 1'b0;
			pready_r     <= 1'b0;
			prdata_r     <= 32'h0000_0000;
			pslverr_r    <= 1'b0;
		end else begin
			phase_r      <= phase_nxt;
			t1_r         <= t1_nxt;
			t2_r         <= t2_nxt;
			pre_r        <= pre_nxt;
			cmp_r        <= cmp_nxt;
			ctrl_r       <= ctrl_nxt;
			period_r     <= period_nxt;
			t2ctl_r      <= t2ctl_nxt;
			flags_r      <= flags_nxt;
			ien_r        <= ien_nxt;
			aux_r        <= aux_nxt;
			duty_lsb_r   <= duty_lsb_nxt;
			latch_r      <= latch_nxt;
			pwm_r        <= pwm_nxt;
			match_prev_r <= match_prev_nxt;
			sevt_r       <= sevt_nxt;
			adc_r        <= adc_nxt;
			pin_out_r    <= pin_out_nxt;
			pin_oe_r     <= pin_oe_nxt;
			pready_r     <= pready_nxt;
			prdata_r     <= prdata_nxt;
			pslverr_r    <= pslverr_nxt;
		end
	end

	assign pready        = pready_r;
	assign prdata        = prdata_r;
	assign pslverr       = pslverr_r;
	assign unit_pin_out  = pin_out_r;
	assign unit_pin_oe   = pin_oe_r;
	assign special_event = sevt_r;
	assign adc_start     = adc_r;

endmodule : compare_and_pwm_unit

// [verification/ccp_chk.sv]
// concurrent checks on the ports of the compare and pwm unit
`timescale 1ns/1ps
`include "ccp_defs.svh"
module ccp_chk (
	// apb slave
	input wire logic           pclk,
	input wire logic           presetn,
	input wire logic           psel,
	input wire logic           penable,
	input wire logic           pwrite,
	input wire logic [7:0]     paddr,
	input wire ccp_pkg::word_t pwdata,
	input wire logic           pready,
	input wire ccp_pkg::word_t prdata,
	input wire logic           pslverr,
	// pin and trigger
	input wire logic           unit_pin_out,
	input wire logic           unit_pin_oe,
	input wire logic           special_event,
	input wire logic           adc_start
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	////////////////////////////////////////////////////////////////////////////
	property p_rdy_pulse; pready |=> !pready; endproperty
	a_rdy_pulse: assert property (p_rdy_pulse)
		else $error("ready held past one cycle");
	property p_rdy_follow; psel && !penable |=> pready; endproperty
	a_rdy_follow: assert property (p_rdy_follow)
		else $error("no answer after setup");
	property p_err_rdy; pslverr |-> pready; endproperty
	a_err_rdy: assert property (p_err_rdy)
		else $error("error without ready");
	property p_sev_pulse; special_event |=> !special_event; endproperty
	a_sev_pulse: assert property (p_sev_pulse)
		else $error("trigger longer than one cycle");
	property p_adc; adc_start |-> special_event; endproperty
	a_adc: assert property (p_adc)
		else $error("conversion start without trigger");
	property p_sev_pin; special_event |-> !unit_pin_oe; endproperty
	a_sev_pin: assert property (p_sev_pin)
		else $error("pin driven in trigger mode");
	property p_zero_ctl;
		psel && penable && pready && pwrite && paddr == `OFS_CONTROL && pwdata[7:0] == 8'h00
			|-> ##[1:2] (!unit_pin_oe && !unit_pin_out);
	endproperty
	a_zero_ctl: assert property (p_zero_ctl)
		else $error("pin not released after control cleared");
	// the driver only comes on as a late effect of a register write
	property p_oe_cause;
		$rose(unit_pin_oe) |-> $past(pready && pwrite) || $past(pready && pwrite, 2);
	endproperty
	a_oe_cause: assert property (p_oe_cause)
		else $error("pin driver enabled without a write");
	c_sev: cover property (special_event);
	c_pin: cover property ($rose(unit_pin_out) && unit_pin_oe);
	c_err: cover property (pslverr);
endmodule : ccp_chk

bind compare_and_pwm_unit ccp_chk i_ccp_chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
	.pwdata, .pready, .prdata, .pslverr, .unit_pin_out, .unit_pin_oe, .special_event, .adc_start);

// [verification/pin_load_model.sv]
// far side of the unit: pin with pull-up and a conversion start counter
`timescale 1ns/1ps
module pin_load_model (
	// clock and reset
	input  wire logic pclk,
	input  wire logic presetn,
	// unit side
	input  wire logic unit_pin_out,
	input  wire logic unit_pin_oe,
	input  wire logic adc_start,
	// observed
	output logic      pin_level,
	output int        adc_count
);
	// a released pin floats up, it never keeps the last driven level
	assign pin_level = unit_pin_oe ? unit_pin_out : 1'b1;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			adc_count <= 0;
		else if (adc_start)
			adc_count <= adc_count + 1;
	end
endmodule : pin_load_model

// [verification/compare_and_pwm_unit_tb.sv]
// self-checking testbench of the compare and pwm unit
`timescale 1ns/1ps
`include "ccp_defs.svh"
module compare_and_pwm_unit_tb;
	import ccp_pkg::*;
	logic       pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
	logic       unit_pin_out, unit_pin_oe, special_event, adc_start, pin_level;
	logic [7:0] paddr;
	word_t      pwdata, prdata, rd;
	int         num_errors, num_checks, seed, n, hi, per, cmp, adc_count;
	int         dq[$];
	compare_and_pwm_unit i_compare_and_pwm_unit (.pclk, .presetn, .psel, .penable, .pwrite,
		.paddr, .pwdata, .pready, .prdata, .pslverr, .unit_pin_out, .unit_pin_oe,
		.special_event, .adc_start);
	pin_load_model i_pin_load_model (.pclk, .presetn, .unit_pin_out, .unit_pin_oe, .adc_start,
		.pin_level, .adc_count);
	////////////////////////////////////////////////////////////////////////////
	task print_verdict;
		$display("checks %0d errors %0d", num_checks, num_errors);
		if (num_errors == 0 && num_checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : print_verdict
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic rw(input logic w, input logic [7:0] a, input byte_t d);
		int i;
		@(posedge pclk);
		psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= {24'h0, d};
		@(posedge pclk);
		penable <= 1;
		for (i = 0; i < 20 && pready !== 1'b1; i++) @(posedge pclk);
		rd = prdata;
		err = pslverr;
		psel <= 0;
		penable <= 0;
		if (i == 20) begin
			num_errors++;
			$display("wrong value at %0t: bus answer timed out", $time);
			print_verdict;
		end
	endtask : rw
	// waits at falling edges, where registered outputs have settled
	task automatic wt(ref logic s, input logic v);
		int i;
		for (i = 0; i < 400 && s !== v; i++) @(negedge pclk);
		if (s !== v) begin
			num_errors++;
			$display("wrong value at %0t: wait timed out", $time);
			print_verdict;
		end
	endtask : wt
	initial begin
		pclk = 0;
		forever #12.5 pclk = ~pclk;
	end
	initial begin
		seed = 49; num_errors = 0; num_checks = 0;
		presetn = 0; psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0;
		repeat (10) @(posedge pclk);
		presetn <= 1;
		rw(0, `OFS_CONTROL, 0); chk(rd, `RST_CONTROL);
		rw(0, `OFS_PERIOD, 0); chk(rd, `RST_PERIOD);
		rw(0, 8'h2c, 0); chk(err, 1);
		// compare set, then clearing control releases the pin
		rw(1, `OFS_AUX, 8'h01);
		rw(1, `OFS_CMP_LOW, 8'h10);
		rw(1, `OFS_CONTROL, MODE_SET);
		wt(unit_pin_out, 1); chk(unit_pin_oe, 1);
		rw(0, `OFS_IRQ_FLAGS, 0); chk(rd[`FLAG_UNIT], 1);
		rw(1, `OFS_CONTROL, 0);
		repeat (2) @(negedge pclk);
		chk({unit_pin_out, unit_pin_oe}, 0);
		// software interrupt only: flag on match, pin left alone
		rw(1, `OFS_T1_HIGH, 0); rw(1, `OFS_T1_LOW, 0); rw(1, `OFS_IRQ_FLAGS, 0);
		rw(1, `OFS_CONTROL, MODE_SWINT);
		repeat (100) @(posedge pclk);
		rw(0, `OFS_IRQ_FLAGS, 0); chk(rd[`FLAG_UNIT], 1);
		chk(unit_pin_oe, 0);
		// special trigger with a random period
		cmp = 8 + ($random(seed) & 15);
		rw(1, `OFS_AUX, 8'h03);
		rw(1, `OFS_T1_HIGH, 0); rw(1, `OFS_T1_LOW, 0);
		rw(1, `OFS_CMP_LOW, cmp); rw(1, `OFS_IRQ_FLAGS, 0);
		rw(1, `OFS_CONTROL, MODE_SPECIAL);
		wt(special_event, 1); chk(unit_pin_oe, 0);
		repeat (8) @(posedge pclk);
		rw(0, `OFS_T1_LOW, 0); chk(rd < cmp, 1);
		rw(0, `OFS_IRQ_FLAGS, 0); chk(rd[2:0], 3'b100);
		chk(adc_count, 1);
		// pwm: limit 3 at 1:1 gives a 16 clock period
		rw(1, `OFS_CONTROL, 0);
		rw(1, `OFS_PERIOD, 8'h03);
		rw(1, `OFS_T2_CONTROL, 8'h04);
		dq = '{6, 1 + ($random(seed) & 14), 15};
		foreach (dq[n]) begin
			rw(1, `OFS_CMP_LOW, dq[n] >> 2);
			rw(1, `OFS_CONTROL, {2'b00, dq[n][1:0], 4'b1100});
			// the first rise may still use the old duty
			repeat (2) begin
				wt(pin_level, 0);
				wt(pin_level, 1);
			end
			hi = 0;
			while (pin_level === 1'b1 && hi < 99) begin @(negedge pclk); hi++; end
			per = hi;
			while (pin_level === 1'b0 && per < 99) begin @(negedge pclk); per++; end
			chk(hi, dq[n]);
			chk(per, 4 * (3 + 1));
		end
		rw(1, `OFS_CMP_HIGH, 8'h55);
		rw(0, `OFS_CMP_HIGH, 0); chk(rd, 15 >> 2);
		print_verdict;
	end
endmodule : compare_and_pwm_unit_tb
